// *** logic/rrc_pkg.sv ***
// Package with encodings and reset values for the rotate-right-through-carry slice
package rrc_pkg;
	localparam logic [5:0]  RRC_OPC_HI      = 6'h0C;
	localparam int          RRC_OPC_MSB     = 11;
	localparam int          RRC_OPC_LSB     = 6;
	localparam int          RRC_DEST_BIT    = 5;
	localparam int          RRC_ADDR_MSB    = 4;
	localparam int          RRC_ADDR_LSB    = 0;
	localparam logic [7:0]  RRC_ACC_RST     = 8'h00;
	localparam logic        RRC_CARRY_RST   = 1'b0;
	localparam logic [7:0]  RRC_WDATA_RST   = 8'h00;
	localparam logic [4:0]  RRC_WADDR_RST   = 5'h00;
	localparam int          RRC_EXEC_CYCLES = 1;
	typedef enum logic [0:0] {
		RRC_DEST_ACC  = 1'b0,
		RRC_DEST_FILE = 1'b1
	} rrc_dest_t;
endpackage

// *** logic/rrc_dec_if.sv ***
// Interface carrying decoded opcode fields from decoder to datapath
`timescale 1ns/1ps
interface rrc_dec_if;
	logic       hit;
	logic       dest;
	logic [4:0] addr;
	modport dec (output hit, output dest, output addr);
	modport dp  (input hit, input dest, input addr);
endinterface

// *** logic/rrc_decoder.sv ***
// Opcode decoder for the rotate-right-through-carry instruction
`timescale 1ns/1ps
module rrc_decoder
	import rrc_pkg::*;
(
	// Instruction word
	input  wire logic [11:0] instr,
	input  wire logic        instr_valid,
	// Decoded fields
	rrc_dec_if.dec           dec
);
	function automatic logic is_rotate_right_carry_op(input logic [11:0] w);
		return w[RRC_OPC_MSB:RRC_OPC_LSB] == RRC_OPC_HI;
	endfunction

	always_comb begin
		dec.hit  = instr_valid && is_rotate_right_carry_op(instr);
		dec.dest = instr[RRC_DEST_BIT];
		dec.addr = instr[RRC_ADDR_MSB:RRC_ADDR_LSB];
	end
endmodule

// *** logic/rrc_top.sv ***
// Rotate-right-through-carry datapath slice of the 8-bit core
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module rrc_top
	import rrc_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// Instruction from the decoder stage, one per cycle
	input  wire logic [11:0] instr,
	input  wire logic        instr_valid,
	// Register file read port, combinational on file_raddr
	output logic      [4:0]  file_raddr,
	input  wire logic [7:0]  file_rdata,
	// Register file write port
	output logic             file_we,
	output logic      [4:0]  file_waddr,
	output logic      [7:0]  file_wdata,
	// Architectural state
	output logic      [7:0]  acc,
	output logic             carry,
	output logic             zero_we,
	output logic             dcarry_we,
	output logic             done
);
	rrc_dec_if dec_bus ();

	rrc_decoder u_dec (
		.instr       (instr),
		.instr_valid (instr_valid),
		.dec         (dec_bus)
	);

	// ----------------------------------------------------------------
	// Execute datapath
	// ----------------------------------------------------------------
	logic [7:0] rot;
	logic       exec_acc;
	logic       exec_file;

	// Operand read and rotate are combinational: the register file answers within the cycle
	function automatic logic [7:0] rot_right(input logic [7:0] v, input logic c);
		return {c, v[7:1]};
	endfunction

	assign file_raddr = dec_bus.addr;
	assign rot        = rot_right(file_rdata, carry_q);
	assign exec_acc   = dec_bus.hit && (dec_bus.dest == RRC_DEST_ACC);
	assign exec_file  = dec_bus.hit && (dec_bus.dest == RRC_DEST_FILE);

	// ----------------------------------------------------------------
	// Accumulator, carry and completion pulse
	// ----------------------------------------------------------------
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic       carry_q;
	logic       carry_d;
	logic       done_q;
	logic       done_d;

	always_comb begin
		acc_d   = acc_q;
		carry_d = carry_q;
		done_d  = 1'b0;
		if (dec_bus.hit) begin
			// Carry is the only status bit this instruction may move
			carry_d = file_rdata[0];
			done_d  = 1'b1;
		end
		if (exec_acc) begin
			acc_d = rot;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q   <= RRC_ACC_RST;
			carry_q <= RRC_CARRY_RST;
			done_q  <= 1'b0;
		end else begin
			acc_q   <= acc_d;
			carry_q <= carry_d;
			done_q  <= done_d;
		end
	end

	// ----------------------------------------------------------------
	// Register file write-back
	// ----------------------------------------------------------------
	// Registered one cycle after execute; a back-to-back read of the same
	// address relies on forwarding inside the register file
	logic       we_q;
	logic       we_d;
	logic [4:0] waddr_q;
	logic [4:0] waddr_d;
	logic [7:0] wdata_q;
	logic [7:0] wdata_d;

	always_comb begin
		we_d    = 1'b0;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		if (exec_file) begin
			we_d    = 1'b1;
			waddr_d = dec_bus.addr;
			wdata_d = rot;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			we_q    <= 1'b0;
			waddr_q <= RRC_WADDR_RST;
			wdata_q <= RRC_WDATA_RST;
		end else begin
			we_q    <= we_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign acc        = acc_q;
	assign carry      = carry_q;
	assign file_we    = we_q;
	assign file_waddr = waddr_q;
	assign file_wdata = wdata_q;
	assign done       = done_q;
	// Zero and digit-carry are never touched by this instruction
	assign zero_we    = 1'b0;
	assign dcarry_we  = 1'b0;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	localparam int COMMIT_LAT = RRC_EXEC_CYCLES;

	// Cycles since the last executed rotate, saturating at 3 so it never wraps
	logic [1:0] since_hit_q;
	logic [1:0] since_hit_d;

	always_comb begin
		since_hit_d = since_hit_q;
		if (dec_bus.hit) begin
			since_hit_d = 2'h1;
		end else if (since_hit_q != 2'h3) begin
			since_hit_d = since_hit_q + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			since_hit_q <= 2'h3;
		end else begin
			since_hit_q <= since_hit_d;
		end
	end

	AST_DECODE: assert property (dec_bus.hit == (instr_valid && instr[11:6] == 6'h0C))
		else $error("decode mismatch");

	AST_RADDR: assert property (file_raddr == instr[4:0])
		else $error("operand address not taken from the opcode");

	AST_CARRY: assert property (dec_bus.hit |=> carry_q == $past(file_rdata[0]))
		else $error("carry not old bit 0");

	AST_ROT: assert property (dec_bus.hit && !dec_bus.dest
		|=> acc_q == {$past(carry_q), $past(file_rdata[7:1])})
		else $error("rotation wrong");

	AST_CARRY_IN: assert property (exec_acc && carry_q |=> acc_q[7])
		else $error("old carry did not enter bit 7");

	AST_ACC_NOWR: assert property (dec_bus.hit && !dec_bus.dest |=> !file_we)
		else $error("file written for acc destination");

	AST_WB_HOLD: assert property (!exec_file
		|=> $stable(file_waddr) && $stable(file_wdata))
		else $error("write-back fields moved without a file write");

	AST_FILE_WR: assert property (dec_bus.hit && dec_bus.dest
		|=> file_we && file_waddr == $past(dec_bus.addr) && acc_q == $past(acc_q))
		else $error("file writeback wrong");

	AST_FILE_DATA: assert property (exec_file
		|=> file_wdata == {$past(carry_q), $past(file_rdata[7:1])})
		else $error("written back value is not the rotated operand");

	AST_FLAGS: assert property (!zero_we && !dcarry_we)
		else $error("other flag touched");

	AST_HOLD: assert property (!dec_bus.hit |=> $stable(carry_q) && $stable(acc_q) && !file_we)
		else $error("state changed without op");

	AST_ONECYC: assert property (dec_bus.hit |=> done ##1 (done == $past(dec_bus.hit)))
		else $error("commit not single cycle");

	AST_LATENCY: assert property (dec_bus.hit |-> ##[COMMIT_LAT:COMMIT_LAT] done)
		else $error("commit latency wrong");

	AST_DONE_CNT: assert property (done == (since_hit_q == COMMIT_LAT))
		else $error("done pulse not tied to one executed rotate");

	AST_DONE_WE: assert property (file_we |-> done)
		else $error("file write without completion");

	// Reset values are checked while reset is held, so the default disable is overridden
	AST_RST_VALUES: assert property (@(posedge mclk) disable iff (1'b0)
		!reset_n |-> acc_q == RRC_ACC_RST && carry_q == RRC_CARRY_RST
		&& !file_we && !done)
		else $error("state not at reset values");

	// Coverage of the main scenarios
	COV_ACC:   cover property (dec_bus.hit && !dec_bus.dest);
	COV_FILE:  cover property (dec_bus.hit && dec_bus.dest);
	COV_B2B:   cover property (dec_bus.hit ##1 dec_bus.hit);
	COV_CIN:   cover property (exec_acc && carry_q && file_rdata[0]);
	COV_MISS:  cover property (instr_valid && !dec_bus.hit);
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the rotate-right-through-carry slice
`timescale 1ns/1ps
module tb;
	import rrc_pkg::*;
	logic        mclk, reset_n, instr_valid, file_we, carry, zero_we, dcarry_we, done, c_m;
	logic [11:0] instr;
	logic [4:0]  file_raddr, file_waddr;
	logic [7:0]  file_rdata, file_wdata, acc, acc_m;
	logic [7:0]  mem [32];
	int          n_errors, n_compared;
	logic [11:0] w;

	rrc_top dut (.mclk(mclk), .reset_n(reset_n), .instr(instr), .instr_valid(instr_valid),
		.file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc), .carry(carry),
		.zero_we(zero_we), .dcarry_we(dcarry_we), .done(done));

	// ----------------------------------------
	// Register file stand-in
	// ----------------------------------------
	assign file_rdata = mem[file_raddr];
	always @(posedge mclk) if (file_we === 1'b1) mem[file_waddr] <= file_wdata;

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Returns new carry above the rotated byte
	function automatic logic [8:0] rot(input logic [7:0] v, input logic c);
		return {v[0], c, v[7:1]};
	endfunction

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Called at a falling edge; one instruction, then one idle cycle
	task op(input logic [11:0] iw, input logic v);
		logic [8:0] r;
		logic       hit;
		hit = v && (iw[11:6] == RRC_OPC_HI);
		r = rot(mem[iw[4:0]], c_m);
		instr = iw;
		instr_valid = v;
		@(negedge mclk);
		instr_valid = 1'b0;
		instr = 12'($urandom);
		if (hit) c_m = r[8];
		if (hit && !iw[5]) acc_m = r[7:0];
		chk({done, carry, acc}, {hit, c_m, acc_m});
		chk({file_we, zero_we, dcarry_we}, {hit & iw[5], 2'b00});
		if (hit && iw[5]) chk({file_waddr, file_wdata}, {iw[4:0], r[7:0]});
		@(negedge mclk);
		chk({done, file_we}, 2'b00);
	endtask

	task results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		instr = 12'h000;
		instr_valid = 1'b0;
		c_m = RRC_CARRY_RST;
		acc_m = RRC_ACC_RST;
		void'($urandom(32'hDE0A));
		for (int i = 0; i < 32; i++) mem[i] = 8'($urandom);
		mem[5] = 8'hE6;
		repeat (16) @(negedge mclk);
		chk({acc, carry, done, file_we}, {RRC_ACC_RST, RRC_CARRY_RST, 2'b00});
		chk({file_waddr, file_wdata}, {RRC_WADDR_RST, RRC_WDATA_RST});
		reset_n = 1'b1;
		op(12'h305, 1'b1);
		op(12'h325, 1'b1);
		op(12'h31F, 1'b1);
		op(12'h300, 1'b1);
		op(12'h305, 1'b0);
		// Near misses: neighbouring opcodes must be ignored
		op(12'h345, 1'b1);
		op(12'h2C5, 1'b1);
		for (int i = 0; i < 300; i++) begin
			w = 12'($urandom);
			if ($urandom % 4 != 0) w[11:6] = RRC_OPC_HI;
			op(w, ($urandom % 8) != 0);
		end
		results();
	end

	// Run needs well under 1000 cycles; cut short far beyond that
	initial begin
		#200000;
		n_errors++;
		results();
	end
endmodule
